// [rtl/swire_host_defines.vh]
// Operation
// - Host starts every slot by pulling low
// - Bytes of eight bits, MSB first
// - Address byte high nibble carries opcode
// - Ninth slot returns acknowledge bit
// - No pause inside byte or acknowledge
// - Reset low time; discharge for busy
// - Recovery high time before discovery request
// - Discovery acknowledge before any command; host sets o_discovered and accepts commands even without it
// - Host samples discovery at sample point
// - Start/stop high time after discovery
// - Slot length within mode limits
// - Long low zero, short low one
// - Acknowledge is zero, not-acknowledge one
// - Zero pulse 6-16us fast, 24-64us std
// - One pulse 1-2us fast, 4-8us std
// - Start/stop high 150us fast, 600us std
`ifndef SWIRE_HOST_DEFINES_VH
`define SWIRE_HOST_DEFINES_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_MHZ 100

// ----------------------------------------
// High-speed timings, microseconds
// ----------------------------------------
`define HS_ZERO_US 8
`define HS_ONE_US 1
`define HS_SLOT_US 20
`define HS_RD_US 1
`define HS_SAMPLE_US 2
`define HS_HTSS_US 150
`define HS_RESET_US 150

// ----------------------------------------
// Standard-speed timings, microseconds
// ----------------------------------------
`define SS_ZERO_US 32
`define SS_ONE_US 4
`define SS_SLOT_US 80
`define SS_RD_US 4
`define SS_SAMPLE_US 8
`define SS_HTSS_US 600
`define SS_RESET_US 480

// ----------------------------------------
// Reset and discovery, microseconds
// ----------------------------------------
`define DSCHG_US 150
`define RRT_US 8
`define DRR_US 1
`define MSDR_US 2
`define DISC_SLOT_US 20

// ----------------------------------------
// Frame
// ----------------------------------------
`define BYTE_BITS 8
`define CNT_W 20

`endif

// [rtl/swire_slot_timer.v]
`timescale 1ns/10ps
`include "swire_host_defines.vh"
module swire_slot_timer #(
  parameter CNT_W = `CNT_W
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Control
  input wire i_start,
  input wire [CNT_W-1:0] i_low_cycles,
  input wire [CNT_W-1:0] i_sample_cycles,
  input wire [CNT_W-1:0] i_total_cycles,
  // Status
  output reg o_drive_low,
  output wire o_sample,
  output wire o_done,
  output wire o_busy
);
  reg [CNT_W-1:0] count;
  reg running;

  // ----------------------------------------
  // Slot counter
  // ----------------------------------------
  // counter-timed slot
  always @(posedge i_clock) begin
    if (i_rst) begin
      count <= {CNT_W{1'b0}};
      running <= 1'b0;
      o_drive_low <= 1'b0;
    end else if (i_start) begin
      count <= {CNT_W{1'b0}};
      running <= 1'b1;
      o_drive_low <= 1'b1;
    end else if (running) begin
      count <= count + 1'b1;
      if (count + 1'b1 >= i_low_cycles) begin
        o_drive_low <= 1'b0;
      end
      if (count + 1'b1 >= i_total_cycles) begin
        running <= 1'b0;
      end
    end
  end

  assign o_sample = running && (count == i_sample_cycles);
  assign o_done = running && (count + 1'b1 >= i_total_cycles);
  assign o_busy = running;
endmodule // swire_slot_timer

// [rtl/swire_host.v]
`timescale 1ns/10ps
`include "swire_host_defines.vh"
module swire_host #(
  parameter CNT_W = `CNT_W,
  parameter HS_HTSS_CYC = `HS_HTSS_US * `CLK_MHZ,
  parameter SS_HTSS_CYC = `SS_HTSS_US * `CLK_MHZ,
  parameter HS_RESET_CYC = `HS_RESET_US * `CLK_MHZ,
  parameter SS_RESET_CYC = `SS_RESET_US * `CLK_MHZ,
  parameter DSCHG_CYC = `DSCHG_US * `CLK_MHZ
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Commands
  input wire i_reset_req,
  input wire i_discharge,
  input wire i_std_speed,
  input wire i_byte_req,
  input wire i_byte_read,
  input wire [7:0] i_byte,
  input wire i_ack_out,
  input wire i_stop_req,
  // Answers
  output wire o_ready,
  output reg o_done,
  output reg o_present,
  output reg [7:0] o_byte,
  output reg o_ack_in,
  output reg o_discovered,
  // Line
  input wire i_line,
  output wire o_line,
  output wire o_line_oe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RESET = 3'd1;
  localparam ST_RECOVER = 3'd2;
  localparam ST_DISC = 3'd3;
  localparam ST_HIGH = 3'd4;
  localparam ST_BITS = 3'd5;

  localparam [CNT_W-1:0] HS_ZERO = `HS_ZERO_US * `CLK_MHZ;
  localparam [CNT_W-1:0] HS_ONE = `HS_ONE_US * `CLK_MHZ;
  localparam [CNT_W-1:0] HS_SLOT = `HS_SLOT_US * `CLK_MHZ;
  localparam [CNT_W-1:0] HS_RD = `HS_RD_US * `CLK_MHZ;
  localparam [CNT_W-1:0] HS_SMP = `HS_SAMPLE_US * `CLK_MHZ;
  localparam [CNT_W-1:0] SS_ZERO = `SS_ZERO_US * `CLK_MHZ;
  localparam [CNT_W-1:0] SS_ONE = `SS_ONE_US * `CLK_MHZ;
  localparam [CNT_W-1:0] SS_SLOT = `SS_SLOT_US * `CLK_MHZ;
  localparam [CNT_W-1:0] SS_RD = `SS_RD_US * `CLK_MHZ;
  localparam [CNT_W-1:0] SS_SMP = `SS_SAMPLE_US * `CLK_MHZ;
  localparam [CNT_W-1:0] RRT = `RRT_US * `CLK_MHZ;
  localparam [CNT_W-1:0] DRR = `DRR_US * `CLK_MHZ;
  localparam [CNT_W-1:0] MSDR = `MSDR_US * `CLK_MHZ;
  localparam [CNT_W-1:0] DSLOT = `DISC_SLOT_US * `CLK_MHZ;

  reg [2:0] state;
  reg [CNT_W-1:0] count;
  reg [3:0] bit_idx;
  reg [8:0] shift;
  reg [7:0] rx;
  reg reading;
  reg std_mode;
  reg hold_low;
  reg line_meta;
  reg line_sync;
  reg slot_start;
  reg [CNT_W-1:0] slot_low;
  reg [CNT_W-1:0] slot_smp;
  reg [CNT_W-1:0] slot_total;
  wire slot_drive;
  wire slot_sample;
  wire slot_done;
  wire slot_busy;

  // ----------------------------------------
  // Line synchroniser
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= i_line;
      line_sync <= line_meta;
    end
  end

  // ----------------------------------------
  // Slot timer
  // ----------------------------------------
  swire_slot_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(slot_start),
    .i_low_cycles(slot_low),
    .i_sample_cycles(slot_smp),
    .i_total_cycles(slot_total),
    .o_drive_low(slot_drive),
    .o_sample(slot_sample),
    .o_done(slot_done),
    .o_busy(slot_busy)
  );

  assign o_line = 1'b0;
  assign o_line_oe_n = ~(hold_low | slot_drive);
  assign o_ready = (state == ST_IDLE) && !slot_busy;

  // Slot timing for one data bit
  function [CNT_W-1:0] bit_low;
    input std;
    input rd;
    input b;
    begin
      if (rd) begin
        bit_low = std ? SS_RD : HS_RD;
      end else if (b) begin
        bit_low = std ? SS_ONE : HS_ONE;
      end else begin
        bit_low = std ? SS_ZERO : HS_ZERO;
      end
    end
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
      count <= {CNT_W{1'b0}};
      bit_idx <= 4'h0;
      shift <= 9'h000;
      rx <= 8'h00;
      reading <= 1'b0;
      std_mode <= 1'b0;
      hold_low <= 1'b0;
      slot_start <= 1'b0;
      slot_low <= {CNT_W{1'b0}};
      slot_smp <= {CNT_W{1'b0}};
      slot_total <= {CNT_W{1'b0}};
      o_done <= 1'b0;
      o_present <= 1'b0;
      o_byte <= 8'h00;
      o_ack_in <= 1'b1;
      o_discovered <= 1'b0;
    end else begin
      slot_start <= 1'b0;
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (!slot_busy && i_reset_req) begin
            hold_low <= 1'b1;
            count <= {CNT_W{1'b0}};
            o_discovered <= 1'b0;
            state <= ST_RESET;
          end else if (!slot_busy && o_discovered && i_stop_req) begin
            count <= {CNT_W{1'b0}};
            state <= ST_HIGH;
          end else if (!slot_busy && o_discovered && i_byte_req) begin
            shift <= {i_byte, i_ack_out};
            reading <= i_byte_read;
            bit_idx <= 4'h0;
            rx <= 8'h00;
            state <= ST_BITS;
          end
        end
        ST_RESET: begin
          count <= count + 1'b1;
          if (count + 1'b1 >= (i_discharge ? DSCHG_CYC[CNT_W-1:0] :
              (std_mode ? SS_RESET_CYC[CNT_W-1:0] : HS_RESET_CYC[CNT_W-1:0]))) begin
            hold_low <= 1'b0;
            count <= {CNT_W{1'b0}};
            std_mode <= i_std_speed;
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (line_sync) begin
            count <= count + 1'b1;
          end
          if (count + 1'b1 >= RRT) begin
            slot_low <= DRR;
            slot_smp <= MSDR;
            slot_total <= DSLOT;
            slot_start <= 1'b1;
            state <= ST_DISC;
          end
        end
        ST_DISC: begin
          if (slot_sample) begin
            o_present <= ~line_sync;
          end
          if (slot_done) begin
            count <= {CNT_W{1'b0}};
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          count <= count + 1'b1;
          if (count + 1'b1 >= (std_mode ? SS_HTSS_CYC[CNT_W-1:0] : HS_HTSS_CYC[CNT_W-1:0])) begin
            o_discovered <= 1'b1;
            o_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_BITS: begin
          if (!slot_busy && !slot_start) begin
            slot_low <= bit_low(std_mode, (bit_idx < 4'd8) ? reading : !reading, shift[8]);
            slot_smp <= std_mode ? SS_SMP : HS_SMP;
            slot_total <= std_mode ? SS_SLOT : HS_SLOT;
            slot_start <= 1'b1;
          end
          if (slot_sample) begin
            if (bit_idx < 4'd8) begin
              rx <= {rx[6:0], line_sync};
            end else begin
              o_ack_in <= line_sync;
            end
          end
          if (slot_done) begin
            shift <= {shift[7:0], 1'b0};
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 4'd8) begin
              o_byte <= rx;
              o_done <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // swire_host

// [dv/swire_host_properties.sv]
`timescale 1ns/10ps
module swire_host_properties #(
  parameter HS_RESET_CYC = 1500
) (
  // Watched ports
  input wire i_clock,
  input wire i_rst,
  input wire i_reset_req,
  input wire i_byte_req,
  input wire i_stop_req,
  input wire o_ready,
  input wire o_done,
  input wire o_discovered,
  input wire o_line,
  input wire o_line_oe_n
);
  reg [19:0] lo;
  reg [19:0] hi;
  always @(posedge i_clock) begin
    lo <= (i_rst || o_line_oe_n) ? 20'h00000 : lo + 20'h00001;
    hi <= (i_rst || !o_line_oe_n) ? 20'h00000 : hi + 20'h00001;
  end
  chk_reset_quiet: assert property (@(posedge i_clock) i_rst |=> o_line_oe_n && !o_done && !o_discovered)
    else $error("active after reset");
  chk_done_pulse: assert property (@(posedge i_clock) disable iff (i_rst) o_done |=> !o_done)
    else $error("done not a pulse");
  chk_slot_start: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ready && o_discovered && i_byte_req && !i_reset_req && !i_stop_req |-> ##[1:3] !o_line_oe_n)
    else $error("slot not started low");
  chk_line_low: assert property (@(posedge i_clock) disable iff (i_rst) o_line == 1'b0)
    else $error("line data not low");
  chk_pulse_width: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_line_oe_n) |-> lo inside {[100:200], [600:1600]} || lo >= HS_RESET_CYC)
    else $error("low pulse width");
  chk_recovery_gap: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_line_oe_n) && o_discovered |-> hi >= 200)
    else $error("slot high too short");
  chk_refuse_early: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ready && !o_discovered && !i_reset_req |=> o_ready)
    else $error("command before discovery");
  chk_no_pause: assert property (@(posedge i_clock) disable iff (i_rst) !o_ready && o_discovered |-> hi <= 2500)
    else $error("pause inside byte");
endmodule // swire_host_properties

// [dv/swire_device_model.sv]
`timescale 1ns/10ps
module swire_device_model #(
  parameter RST_MIN = 1200,
  parameter DSCHG_MIN = 2400
) (
  // Control
  input wire i_clock,
  input wire i_busy,
  input wire i_read,
  input wire i_nack,
  input wire [7:0] i_tx,
  // Line
  input wire i_line,
  output reg o_pull,
  output reg [7:0] o_rx,
  output reg o_rx_ack
);
  integer lo = 0;
  integer t = 0;
  integer hold = 0;
  integer k = 0;
  reg prev = 1'b1;
  reg fresh = 1'b0;
  reg slot = 1'b0;
  reg bz = 1'b0;
  initial begin
    o_pull = 1'b0;
    o_rx = 8'h00;
    o_rx_ack = 1'b1;
  end
  always @(posedge i_clock) begin
    bz = bz | i_busy;
    t = t + 1;
    if (i_line && !prev && lo >= (bz ? DSCHG_MIN : RST_MIN)) begin
      bz = 1'b0;
      fresh = 1'b1;
      k = 0;
    end
    else if (!i_line && prev && !bz) begin
      t = 0;
      hold = fresh || (i_read ? (k < 8 && !i_tx[7 - k]) : (k == 8 && !i_nack)) ? 400 : 0;
      slot = !fresh;
      fresh = 1'b0;
    end
    if (slot && t == 400) begin
      if (!i_read && k < 8) o_rx[7 - k] <= i_line;
      if (i_read && k == 8) o_rx_ack <= i_line;
      k = (k == 8) ? 0 : k + 1;
      slot = 1'b0;
    end
    lo = i_line ? 0 : lo + 1;
    prev = i_line;
    o_pull <= hold > 0;
    if (hold > 0) hold = hold - 1;
  end
endmodule // swire_device_model

// [dv/swire_host_test.sv]
`timescale 1ns/10ps
module swire_host_test;
  reg i_clock, i_rst, rst_req, dis, b_req, b_rd, ack_out, stop_req, busy, std_sel;
  reg [7:0] tx;
  wire ready, done, present, ack_in, found, h_line, oe_n, pull, d_ack, line;
  wire [7:0] rx, d_rx;
  integer fail_count = 0;
  integer checked = 0;
  integer n, k;
  assign line = (oe_n | h_line) & ~pull;
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  swire_host #(.HS_HTSS_CYC(200), .SS_HTSS_CYC(800), .HS_RESET_CYC(1500), .DSCHG_CYC(2500)) u_swire_host (
    .i_clock(i_clock), .i_rst(i_rst), .i_reset_req(rst_req), .i_discharge(dis), .i_std_speed(std_sel),
    .i_byte_req(b_req), .i_byte_read(b_rd), .i_byte(tx), .i_ack_out(ack_out), .i_stop_req(stop_req),
    .o_ready(ready), .o_done(done), .o_present(present), .o_byte(rx), .o_ack_in(ack_in),
    .o_discovered(found), .i_line(line), .o_line(h_line), .o_line_oe_n(oe_n));
  swire_device_model u_swire_device_model (
    .i_clock(i_clock), .i_busy(busy), .i_read(b_rd), .i_nack(ack_out), .i_tx(tx),
    .i_line(line), .o_pull(pull), .o_rx(d_rx), .o_rx_ack(d_ack));
  task complete_run;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wait_done;
    begin
      n = 0;
      @(posedge i_clock);
      while (done !== 1'b1 && n < 30000) begin
        @(posedge i_clock);
        n = n + 1;
      end
      if (n >= 30000) fail_count = fail_count + 1;
    end
  endtask
  task do_reset(input d, input [7:0] exp);
    begin
      rst_req <= 1'b1;
      dis <= d;
      @(posedge i_clock);
      rst_req <= 1'b0;
      wait_done;
      check(present, exp);
      check(found, 8'h01);
    end
  endtask
  task do_byte(input rd, input [7:0] data, input ack);
    begin
      b_req <= 1'b1;
      b_rd <= rd;
      tx <= data;
      ack_out <= ack;
      @(posedge i_clock);
      b_req <= 1'b0;
      wait_done;
      check(rd ? rx : d_rx, data);
      check(rd ? d_ack : ack_in, ack);
    end
  endtask
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    {i_rst, rst_req, dis, b_req, b_rd, ack_out, stop_req, busy, std_sel, tx} = 17'h10000;
    n = $urandom(32'h0C58);
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    b_req <= 1'b1;
    @(posedge i_clock);
    b_req <= 1'b0;
    repeat (20) @(posedge i_clock);
    check(oe_n, 8'h01);
    do_reset(1'b0, 8'h01);
    for (k = 0; k < 2; k = k + 1) do_byte(1'b0, 8'($urandom), k[0]);
    do_byte(1'b1, 8'($urandom), 1'($urandom));
    stop_req <= 1'b1;
    @(posedge i_clock);
    stop_req <= 1'b0;
    wait_done;
    check(n >= 199, 8'h01);
    busy <= 1'b1;
    @(posedge i_clock);
    busy <= 1'b0;
    do_reset(1'b0, 8'h00);
    std_sel <= 1'b1;
    do_reset(1'b1, 8'h01);
    // Discharge, recovery, discovery slot, then standard-speed high time
    check(n >= 6100 && n < 6200, 8'h01);
    complete_run;
  end
endmodule // swire_host_test
bind swire_host swire_host_properties #(.HS_RESET_CYC(HS_RESET_CYC)) u_swire_host_properties (
  .i_clock(i_clock), .i_rst(i_rst), .i_reset_req(i_reset_req), .i_byte_req(i_byte_req), .i_stop_req(i_stop_req),
  .o_ready(o_ready), .o_done(o_done), .o_discovered(o_discovered), .o_line(o_line), .o_line_oe_n(o_line_oe_n));
